// ==== dv/eeprom_guard_monitor.sv ====
// port checker for the eeprom guard
// bound from tb onto eeprom_guard; one clock domain
`default_nettype none
module eeprom_guard_monitor #(
  parameter int unsigned WDOG_CYC = 200
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        wake_pin,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        awake
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic        acc;
  int unsigned awk_cnt;
  assign acc = psel && penable && !pready;
  // no slack cycle: awake stays high for exactly WDOG_CYC cycles, so the bound is tight
  always_ff @(posedge sys_clk)
    if (!rst_n || !awake)
      awk_cnt <= 0;
    else
      awk_cnt <= awk_cnt + 1;
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  answer_next_a: assert property (acc |=> pready)
    else $error("access not answered next cycle");
  ready_cause_a: assert property (pready |-> $past(acc))
    else $error("ready without access");
  align_err_a: assert property (
    acc && (paddr[1:0] != 2'b00 || paddr > 8'h24) |=> pready && pslverr)
    else $error("bad address not refused");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused read not zero");
  wake_start_a: assert property (
    $rose(wake_pin) && !awake |-> ##[1:6] awake)
    else $error("wake token ignored");
  wake_only_a: assert property ($rose(awake) |-> $past(wake_pin))
    else $error("woke without token");
  wdog_bound_a: assert property (awk_cnt <= WDOG_CYC)
    else $error("watchdog did not force sleep");
  reset_quiet_a: assert property (disable iff (1'b0)
    !rst_n |=> !pready && !awake && !pslverr)
    else $error("outputs active in reset");
  cover property (pslverr);
  cover property ($rose(awake));
  cover property ($fell(awake));
endmodule
`default_nettype wire

// ==== dv/host_model.sv ====
// host side model: issues wake tokens on the wake pin
// assumes tb calls wake_token between accesses
`default_nettype none
module host_model (
  input wire logic sys_clk,
  output var logic wake_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial wake_pin = 1'b0;
  // held long enough for the two-flop synchroniser
  task automatic wake_token();
    @(posedge sys_clk);
    wake_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    wake_pin <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the eeprom guard
// assumes short watchdog and command times set below
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned WD = 3000;
  localparam logic [7:0] RO = eeprom_guard_pkg::OP_READ;
  localparam logic [7:0] WO = eeprom_guard_pkg::OP_WRITE;
  localparam logic [7:0] OK = eeprom_guard_pkg::ST_OK;
  localparam logic [7:0] PE = eeprom_guard_pkg::ST_PARSE;
  localparam logic [7:0] RF = eeprom_guard_pkg::ST_EXEC;
  logic        sys_clk, rst_n, wake_pin, psel, penable, pwrite;
  logic        pready, pslverr, awake, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          num_errors, compares, wd_cnt, n;
  eeprom_guard #(.WDOG_CYC(WD), .READ_CYC(10), .WRITE_CYC(40)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .wake_pin(wake_pin),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .awake(awake));
  host_model host (.sys_clk(sys_clk), .wake_pin(wake_pin));
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) wd_cnt <= awake ? wd_cnt + 1 : 0;
  task automatic close_out();
    if (num_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      chk("pready", {31'h0, pready}, 32'h1);
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // f is {offset, slot, block} as reported beside the status
  task automatic cmd(input logic [7:0] op, z, input logic [15:0] loc,
                     input logic s, input logic [7:0] st,
                     input logic [10:0] f);
    apb(1'b1, eeprom_guard_pkg::OFS_LOC, {16'h0000, loc});
    // reserved zone values are never handed to this task
    apb(1'b1, eeprom_guard_pkg::OFS_CMD, {15'h0000, s, z, op});
    apb(1'b0, eeprom_guard_pkg::OFS_STAT, 32'h0);
    chk("status", {24'h0, rd[7:0]}, {24'h0, st});
    if (st == OK)
      chk("fields", {21'h0, rd[18:8]}, {21'h0, f});
  endtask
  initial
  begin
    sys_clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; num_errors = 0; compares = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(0, eeprom_guard_pkg::OFS_STAT, 0);
    chk("stat reset", rd, 32'h0);
    apb(0, 8'h40, 0);
    chk("unmapped", {31'h0, err}, 32'h1);
    apb(1, 8'h06, 32'h1);
    chk("misaligned", {31'h0, err}, 32'h1);
    host.wake_token();
    apb(0, eeprom_guard_pkg::OFS_STAT, 0);
    chk("stat wake", rd, 32'h0020_0011);
    cmd(RO, 8'h00, 16'h001F, 1, OK, 11'h003);
    cmd(RO, 8'h00, 16'h0013, 0, OK, 11'h302);
    cmd(WO, 8'h00, 16'h0003, 0, RF, 0);
    cmd(WO, 8'h00, 16'h0004, 0, OK, 11'h400);
    cmd(WO, 8'h00, 16'h0015, 0, RF, 0);
    cmd(WO, 8'h00, 16'h0007, 1, RF, 0);
    cmd(RO, 8'h01, 16'h000F, 0, RF, 0);
    cmd(WO, 8'h01, 16'h000F, 0, OK, 11'h701);
    cmd(RO, 8'h02, 16'h014D, 0, RF, 0);
    cmd(WO, 8'h02, 16'h014D, 0, OK, 11'h591);
    cmd(WO, 8'h02, 16'h0C45, 1, OK, 11'h08C);
    cmd(WO, 8'h02, 16'h0D40, 1, PE, 0);
    cmd(WO, 8'h02, 16'h0348, 1, PE, 0);
    cmd(WO, 8'h02, 16'h0101, 0, PE, 0);
    cmd(WO, 8'h02, 16'h0249, 0, OK, 11'h192);
    apb(0, eeprom_guard_pkg::OFS_BADDR, 0);
    chk("baddr", rd, 32'h0008_0044);
    cmd(WO, 8'h02, 16'h024A, 0, PE, 0);
    cmd(RO, 8'h02, 16'h0E40, 0, PE, 0);
    cmd(8'h55, 8'h00, 16'h0000, 0, PE, 0);
    apb(1, eeprom_guard_pkg::OFS_SECRET, 32'h0000_0200);
    cmd(WO, 8'h02, 16'h014D, 0, RF, 0);
    cmd(WO, 8'h02, 16'h014D, 1, OK, 11'h091);
    apb(1, eeprom_guard_pkg::OFS_SECRET, 32'h0200_0000);
    apb(1, eeprom_guard_pkg::OFS_CTRL, 32'h6);
    cmd(RO, 8'h01, 16'h000F, 0, OK, 11'h701);
    cmd(WO, 8'h01, 16'h000F, 0, RF, 0);
    cmd(RO, 8'h02, 16'h014D, 0, RF, 0);
    cmd(RO, 8'h02, 16'h0150, 0, OK, 11'h0A1);
    cmd(WO, 8'h02, 16'h0150, 0, RF, 0);
    apb(1, eeprom_guard_pkg::OFS_WPOL, 32'h0000_0400);
    cmd(WO, 8'h02, 16'h0150, 0, OK, 11'h0A1);
    apb(1, eeprom_guard_pkg::OFS_CTRL, 32'hE);
    cmd(WO, 8'h01, 16'h000F, 0, OK, 11'h701);
    apb(1, eeprom_guard_pkg::OFS_LIMIT, 32'h1);
    apb(1, eeprom_guard_pkg::OFS_CTRL, 32'h1E);
    cmd(WO, 8'h02, 16'h0148, 1, RF, 0);
    apb(0, eeprom_guard_pkg::OFS_LIMIT, 0);
    chk("limit", rd, 32'h0);
    cmd(RO, 8'h00, 16'h0000, 0, RF, 0);
    apb(1, eeprom_guard_pkg::OFS_TKEY, 32'hA5A5_5A5A);
    apb(1, eeprom_guard_pkg::OFS_SEED, 32'h1234_ABCD);
    apb(1, eeprom_guard_pkg::OFS_CTRL, 32'h200);
    // awake is registered at the write edge; look one edge later
    @(posedge sys_clk);
    chk("idle", {31'h0, awake}, 32'h0);
    host.wake_token();
    apb(0, eeprom_guard_pkg::OFS_TKEY, 0);
    chk("tkey idle", rd, 32'hA5A5_5A5A);
    apb(0, eeprom_guard_pkg::OFS_SEED, 0);
    chk("seed idle", rd, 32'h1234_ABCD);
    for (n = 0; n < WD && wd_cnt < WD - 25; n++) @(posedge sys_clk);
    cmd(RO, 8'h00, 16'h0000, 0, OK, 11'h000);
    cmd(WO, 8'h00, 16'h0004, 0, 8'hEE, 0);
    for (n = 0; n < 50 && awake; n++) @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
    chk("sleep", {31'h0, awake}, 32'h0);
    apb(0, eeprom_guard_pkg::OFS_TKEY, 0);
    chk("tkey sleep", rd, 32'h0);
    apb(0, eeprom_guard_pkg::OFS_STAT, 0);
    chk("stat sleep", rd, 32'h0);
    // explicit sleep request must clear the volatile stores as well
    host.wake_token();
    apb(1, eeprom_guard_pkg::OFS_SEED, 32'h0000_3C3C);
    apb(1, eeprom_guard_pkg::OFS_CTRL, 32'h100);
    @(posedge sys_clk);
    chk("sleep cmd", {31'h0, awake}, 32'h0);
    apb(0, eeprom_guard_pkg::OFS_SEED, 0);
    chk("seed sleep", rd, 32'h0);
    close_out();
  end
endmodule
bind eeprom_guard eeprom_guard_monitor #(.WDOG_CYC(WDOG_CYC)) mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .wake_pin(wake_pin), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .awake(awake));
`default_nettype wire

// ==== verilog/eeprom_guard.sv ====
// address decode, access legality and watchdog of the secure eeprom
// assumes an apb master on sys_clk and an asynchronous wake pin
// Operation
// - read and write carry one 16-bit location parameter
// - accesses are word aligned; word address drops two low bits
// - sizes 4 or 32 bytes; 32-byte access forces offset to zero
// - config block bits 4-3, otp block bit 3, offset bits 2-0
// - data slot bits 6-3; block bits depend on slot group
// - block limits: cfg 0-3, otp 0-1, data 0-1/0-12/0-2
// - config: never write below 16, write refused at bytes 84-87
// - locked otp: reads always, writes only in consumption mode
// - data 4-byte access only when slot secret flag clear
// - 32-byte access allowed on short blocks, extra bytes zero
// - data block sizes 32, 4, 8 or 32 as per slot group
// - zone select 0 config, 1 otp, 2 data
// - otp writable while unlocked, then per usage mode
// - wake starts watchdog; expiry forces sleep unconditionally
// - only sleep or idle followed by wake restarts watchdog
// - sleep clears key, seed and status; idle keeps key and seed
// - too little watchdog time: timeout status, no execution
// - limited-use count decremented before execution, never below zero
// - watchdog timeout status code is 0xEE
// - read opcode 0x02
// - write opcode 0x12, 4 or 32 bytes
`default_nettype none
module eeprom_guard #(
  parameter int unsigned WDOG_US      = 1000000,
  parameter int unsigned READ_MAX_US  = 1000,
  parameter int unsigned WRITE_MAX_US = 26000,
  parameter int unsigned WDOG_CYC     = WDOG_US * 1000
                                        / eeprom_guard_pkg::CLK_PERIOD_NS,
  parameter int unsigned READ_CYC     = READ_MAX_US * 1000
                                        / eeprom_guard_pkg::CLK_PERIOD_NS,
  parameter int unsigned WRITE_CYC    = WRITE_MAX_US * 1000
                                        / eeprom_guard_pkg::CLK_PERIOD_NS
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        wake_pin,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        awake
);

  typedef struct packed {
    logic                   sync1;
    logic                   sync2;
    logic                   wake_prev;
    eeprom_guard_pkg::pwr_t pwr;
    logic [31:0]            wdog;
    logic [4:0]             ctrl;
    logic [15:0]            secret;
    logic [15:0]            encrd;
    logic [15:0]            wpol;
    logic [7:0]             opcode;
    logic [7:0]             zone;
    logic                   size32;
    logic [15:0]            loc;
    logic [7:0]             status;
    logic [3:0]             block;
    logic [3:0]             slot;
    logic [2:0]             offset;
    logic                   done;
    logic [15:0]            limit;
    logic [31:0]            tkey;
    logic [31:0]            seed;
    logic [10:0]            bidx;
    logic [5:0]             impl;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   awake;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // zone/location decode; reports legality of block and word offset
  function automatic eeprom_guard_pkg::decode_t decode(
    input logic [7:0]  zone,
    input logic [15:0] loc,
    input logic        size32
  );
    eeprom_guard_pkg::decode_t d;
    d = '0;
    d.offset = size32 ? 3'h0 : loc[2:0];
    d.impl = 6'h20;
    if (zone == eeprom_guard_pkg::ZONE_CFG)
    begin
      d.block = {2'b00, loc[4:3]};
      d.legal = d.block <= eeprom_guard_pkg::BLK_MAX_CFG;
    end
    else if (zone == eeprom_guard_pkg::ZONE_OTP)
    begin
      d.block = {3'b000, loc[3]};
      d.legal = d.block <= eeprom_guard_pkg::BLK_MAX_OTP;
    end
    else if (zone == eeprom_guard_pkg::ZONE_DATA)
    begin
      d.slot = loc[6:3];
      if (d.slot < eeprom_guard_pkg::SLOT_BIG)
      begin
        d.block = {3'b000, loc[8]};
        d.legal = d.block <= eeprom_guard_pkg::BLK_MAX_LO;
        d.impl = (d.block == 4'h0) ? 6'h20 : 6'h04;
      end
      else if (d.slot == eeprom_guard_pkg::SLOT_BIG)
      begin
        d.block = loc[11:8];
        d.legal = d.block <= eeprom_guard_pkg::BLK_MAX_S8;
      end
      else
      begin
        d.block = {2'b00, loc[9:8]};
        d.legal = d.block <= eeprom_guard_pkg::BLK_MAX_HI;
        d.impl = (d.block == 4'h2) ? 6'h08 : 6'h20;
      end
      // a word past the implemented bytes only exists for 32-byte access
      if (!size32 && ({1'b0, d.offset, 2'b00} >= d.impl))
        d.legal = 1'b0;
    end
    else
      d.legal = 1'b0;
    d.bidx = {2'b00, d.block, 5'h00} + {6'h00, d.offset, 2'b00};
    return d;
  endfunction

  // read mux; bit 32 flags an unmapped or misaligned address
  function automatic logic [32:0] read_word(
    input logic [7:0] addr,
    input state_t     s
  );
    logic [32:0] r;
    r = '0;
    if (addr[1:0] != 2'b00)
      r[32] = 1'b1;
    else if (addr == eeprom_guard_pkg::OFS_CTRL)
      r[31:0] = {27'h0, s.ctrl};
    else if (addr == eeprom_guard_pkg::OFS_SECRET)
      r[31:0] = {s.encrd, s.secret};
    else if (addr == eeprom_guard_pkg::OFS_WPOL)
      r[31:0] = {16'h0, s.wpol};
    else if (addr == eeprom_guard_pkg::OFS_CMD)
      r[31:0] = {15'h0, s.size32, s.zone, s.opcode};
    else if (addr == eeprom_guard_pkg::OFS_LOC)
      r[31:0] = {16'h0, s.loc};
    else if (addr == eeprom_guard_pkg::OFS_STAT)
      r[31:0] = {10'h0, s.pwr, s.done, s.offset, s.slot, s.block,
                 s.status};
    else if (addr == eeprom_guard_pkg::OFS_LIMIT)
      r[31:0] = {16'h0, s.limit};
    else if (addr == eeprom_guard_pkg::OFS_TKEY)
      r[31:0] = s.tkey;
    else if (addr == eeprom_guard_pkg::OFS_SEED)
      r[31:0] = s.seed;
    else if (addr == eeprom_guard_pkg::OFS_BADDR)
      r[31:0] = {10'h0, s.impl, 5'h00, s.bidx};
    else
      r[32] = 1'b1;
    return r;
  endfunction

  eeprom_guard_pkg::decode_t dec;
  logic        wake_edge;
  logic        wr_now;
  logic        is_rd;
  logic        is_wr;
  logic        perm;
  logic        locked;
  logic [32:0] need_end;
  logic [32:0] rd_word;
  logic [10:0] last_b;

  always_comb
  begin
    st_nxt = st_r;
    dec = '0;
    perm = 1'b0;
    locked = 1'b0;
    is_rd = 1'b0;
    is_wr = 1'b0;
    need_end = '0;
    last_b = '0;
    // only sync2 feeds the edge detector; sync1 is metastability guard
    st_nxt.sync1 = wake_pin;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.wake_prev = st_r.sync2;
    wake_edge = st_r.sync2 & ~st_r.wake_prev;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (st_r.pwr == eeprom_guard_pkg::PWR_AWAKE)
      st_nxt.wdog = st_r.wdog + 32'h1;
    // pready is registered, so the access phase lasts two cycles
    rd_word = read_word(paddr, st_r);
    if (psel && penable && !st_r.pready)
    begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = rd_word[31:0];
      st_nxt.pslverr = rd_word[32];
    end
    wr_now = psel && penable && st_r.pready && pwrite && !st_r.pslverr;
    if (wr_now)
    begin
      if (paddr == eeprom_guard_pkg::OFS_CTRL)
      begin
        st_nxt.ctrl = pwdata[4:0];
        if (pwdata[eeprom_guard_pkg::CTRL_SLEEP])
          st_nxt.pwr = eeprom_guard_pkg::PWR_SLEEP;
        else if (pwdata[eeprom_guard_pkg::CTRL_IDLE])
          st_nxt.pwr = eeprom_guard_pkg::PWR_IDLE;
      end
      else if (paddr == eeprom_guard_pkg::OFS_SECRET)
      begin
        st_nxt.secret = pwdata[15:0];
        st_nxt.encrd = pwdata[31:16];
      end
      else if (paddr == eeprom_guard_pkg::OFS_WPOL)
        st_nxt.wpol = pwdata[15:0];
      else if (paddr == eeprom_guard_pkg::OFS_LOC)
        st_nxt.loc = pwdata[15:0];
      else if (paddr == eeprom_guard_pkg::OFS_LIMIT)
        st_nxt.limit = pwdata[15:0];
      else if (paddr == eeprom_guard_pkg::OFS_TKEY)
        st_nxt.tkey = pwdata;
      else if (paddr == eeprom_guard_pkg::OFS_SEED)
        st_nxt.seed = pwdata;
      else if (paddr == eeprom_guard_pkg::OFS_CMD &&
               st_r.pwr == eeprom_guard_pkg::PWR_AWAKE)
      begin
        // a command is parsed only while awake; asleep it is ignored
        st_nxt.opcode = pwdata[7:0];
        st_nxt.zone = pwdata[15:8];
        st_nxt.size32 = pwdata[eeprom_guard_pkg::CMD_SIZE32];
        st_nxt.done = 1'b1;
        is_rd = pwdata[7:0] == eeprom_guard_pkg::OP_READ;
        is_wr = pwdata[7:0] == eeprom_guard_pkg::OP_WRITE;
        dec = decode(pwdata[15:8], st_r.loc,
                     pwdata[eeprom_guard_pkg::CMD_SIZE32]);
        st_nxt.block = dec.block;
        st_nxt.slot = dec.slot;
        st_nxt.offset = dec.offset;
        st_nxt.bidx = dec.bidx;
        st_nxt.impl = dec.impl;
        last_b = dec.bidx + (pwdata[eeprom_guard_pkg::CMD_SIZE32] ?
                             11'h01F : 11'h003);
        if (pwdata[15:8] == eeprom_guard_pkg::ZONE_CFG)
        begin
          locked = st_r.ctrl[eeprom_guard_pkg::CTRL_CFG_LOCK];
          perm = is_rd || (!locked &&
                 dec.bidx >= eeprom_guard_pkg::CFG_WR_LOW &&
                 (last_b < eeprom_guard_pkg::CFG_XTRA_LO ||
                  dec.bidx > eeprom_guard_pkg::CFG_XTRA_HI));
        end
        else if (pwdata[15:8] == eeprom_guard_pkg::ZONE_OTP)
        begin
          locked = st_r.ctrl[eeprom_guard_pkg::CTRL_OTP_LOCK];
          perm = locked ? (is_rd ||
                 st_r.ctrl[eeprom_guard_pkg::CTRL_OTP_CONS])
                 : is_wr;
        end
        else
        begin
          locked = st_r.ctrl[eeprom_guard_pkg::CTRL_DATA_LOCK];
          // no encryption engine here, so encrypted slots refuse reads
          perm = is_rd ? (locked && !st_r.secret[dec.slot] &&
                          !st_r.encrd[dec.slot])
                 : (!locked || st_r.wpol[dec.slot]);
          if (!pwdata[eeprom_guard_pkg::CMD_SIZE32] &&
              st_r.secret[dec.slot])
            perm = 1'b0;
        end
        need_end = {1'b0, st_r.wdog} +
                   {1'b0, is_wr ? WRITE_CYC : READ_CYC};
        if (!(is_rd || is_wr) || !dec.legal)
          st_nxt.status = eeprom_guard_pkg::ST_PARSE;
        else if (need_end > {1'b0, WDOG_CYC})
          st_nxt.status = eeprom_guard_pkg::ST_WDOG;
        else if (st_r.ctrl[eeprom_guard_pkg::CTRL_LIM_EN] &&
                 st_r.limit == 16'h0000)
          st_nxt.status = eeprom_guard_pkg::ST_EXEC;
        else
        begin
          // count taken before the access; zero is never wrapped
          if (st_r.ctrl[eeprom_guard_pkg::CTRL_LIM_EN])
            st_nxt.limit = st_r.limit - 16'h0001;
          st_nxt.status = perm ? eeprom_guard_pkg::ST_OK
                               : eeprom_guard_pkg::ST_EXEC;
        end
      end
    end
    // power sequencing; wake is the only way back to a fresh watchdog
    if (wake_edge && st_r.pwr != eeprom_guard_pkg::PWR_AWAKE)
    begin
      st_nxt.pwr = eeprom_guard_pkg::PWR_AWAKE;
      st_nxt.wdog = 32'h0;
      st_nxt.status = eeprom_guard_pkg::ST_WAKE;
      st_nxt.done = 1'b0;
    end
    else if (st_r.pwr == eeprom_guard_pkg::PWR_AWAKE &&
             st_r.wdog >= WDOG_CYC - 32'h1)
      st_nxt.pwr = eeprom_guard_pkg::PWR_SLEEP;
    if (st_nxt.pwr == eeprom_guard_pkg::PWR_SLEEP &&
        st_r.pwr != eeprom_guard_pkg::PWR_SLEEP)
    begin
      st_nxt.tkey = 32'h0;
      st_nxt.seed = 32'h0;
      st_nxt.status = eeprom_guard_pkg::ST_OK;
      st_nxt.done = 1'b0;
      st_nxt.block = 4'h0;
      st_nxt.slot = 4'h0;
      st_nxt.offset = 3'h0;
    end
    st_nxt.awake = st_nxt.pwr == eeprom_guard_pkg::PWR_AWAKE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign awake = st_r.awake;

endmodule
`default_nettype wire

// ==== verilog/eeprom_guard_pkg.sv ====
// constants, types and register map of the eeprom address guard
// assumes a single 200 MHz clock and an apb master on the same clock
`default_nettype none
package eeprom_guard_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_SECRET  = 8'h04;
  localparam logic [7:0] OFS_WPOL    = 8'h08;
  localparam logic [7:0] OFS_CMD     = 8'h0C;
  localparam logic [7:0] OFS_LOC     = 8'h10;
  localparam logic [7:0] OFS_STAT    = 8'h14;
  localparam logic [7:0] OFS_LIMIT   = 8'h18;
  localparam logic [7:0] OFS_TKEY    = 8'h1C;
  localparam logic [7:0] OFS_SEED    = 8'h20;
  localparam logic [7:0] OFS_BADDR   = 8'h24;
  // control and command bit positions
  localparam int CTRL_CFG_LOCK  = 0;
  localparam int CTRL_OTP_LOCK  = 1;
  localparam int CTRL_DATA_LOCK = 2;
  localparam int CTRL_OTP_CONS  = 3;
  localparam int CTRL_LIM_EN    = 4;
  localparam int CTRL_SLEEP     = 8;
  localparam int CTRL_IDLE      = 9;
  localparam int CMD_SIZE32     = 16;
  // status codes
  localparam logic [7:0] ST_OK     = 8'h00;
  localparam logic [7:0] ST_PARSE  = 8'h03;
  localparam logic [7:0] ST_EXEC   = 8'h0F;
  localparam logic [7:0] ST_WAKE   = 8'h11;
  localparam logic [7:0] ST_WDOG   = 8'hEE;
  // opcodes and zones
  localparam logic [7:0] OP_READ   = 8'h02;
  localparam logic [7:0] OP_WRITE  = 8'h12;
  localparam logic [7:0] ZONE_CFG  = 8'h00;
  localparam logic [7:0] ZONE_OTP  = 8'h01;
  localparam logic [7:0] ZONE_DATA = 8'h02;
  // configuration zone write limits as byte addresses, then per-zone block limits and the big slot number
  localparam logic [10:0] CFG_WR_LOW  = 11'h010;
  localparam logic [10:0] CFG_XTRA_LO = 11'h054;
  localparam logic [10:0] CFG_XTRA_HI = 11'h057;
  localparam logic [3:0] BLK_MAX_CFG = 4'h3;
  localparam logic [3:0] BLK_MAX_OTP = 4'h1;
  localparam logic [3:0] BLK_MAX_LO  = 4'h1;
  localparam logic [3:0] BLK_MAX_S8  = 4'hC;
  localparam logic [3:0] BLK_MAX_HI  = 4'h2;
  localparam logic [3:0] SLOT_BIG    = 4'h8;

  typedef enum logic [1:0] {
    PWR_SLEEP = 2'b00,
    PWR_IDLE  = 2'b01,
    PWR_AWAKE = 2'b10
  } pwr_t;

  typedef struct packed {
    logic        legal;
    logic [3:0]  block;
    logic [3:0]  slot;
    logic [2:0]  offset;
    logic [5:0]  impl;
    logic [10:0] bidx;
  } decode_t;
endpackage
`default_nettype wire
